// ---- design/tst_engine.sv ----
// table search and table-to-destination engine with register port
//
// How it works
// - search finds the first table word above an address or constant operand
// - search has no start offset; it always begins at the first word
// - on a hit the accumulator gets the word's offset from the start
// - on a miss the fail flag sets and the accumulator gets zero
// - the search position lives in the accumulator and starts at zero
// - fail flag holds only until the next search rewrites it
// - first table word is the pointer; data words follow it
// - each transfer copies the word the stepped pointer points to into destination, then writes the stepped pointer back
// - with its enable held, the transfer runs once per scan
// - pointer reaching the table length wraps to one, never zero
// - pointer zero and pointer equal to length both pick first data word
// - wrap flag rises when the pointer equals the table length
// - wrap flag clears at scan end or at the next transfer
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tst_engine
  import tst_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // register port
  input wire logic [REG_AW-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  // scan pacing
  input wire logic SCAN_END_I,
  // status
  output logic BUSY_O,
  output logic SEARCH_FAIL_O,
  output logic POINTER_WRAP_O,
  output logic IRQ_O
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  tst_state_e state_q;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] stack1_q;
  logic [DATA_W-1:0] operand_q;
  logic [ADDR_W-1:0] dest_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic ttd_en_q;
  logic opnd_addr_q;
  logic [ADDR_W-1:0] base_q;
  logic [LEN_W-1:0] len_q;
  logic [DATA_W-1:0] key_q;
  logic [DATA_W-1:0] ptr_q;
  logic [DATA_W-1:0] data_q;
  logic ttd_pend_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_ev;
  logic wr_ctrl;
  logic go_search;
  logic go_ttd;
  logic ttd_start;
  logic hit;
  logic last;
  logic ptr_ok;
  logic ptr_wrap;
  logic [DATA_W-1:0] data_off;
  logic [DATA_W-1:0] ptr_next;
  logic [ADDR_W-1:0] a_addr;
  logic a_we;
  logic [DATA_W-1:0] a_wdata;
  logic [DATA_W-1:0] a_rdata;
  logic [DATA_W-1:0] b_rdata;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] ptr_cur;
  logic srch_empty;

  ////////////////////////////////////////////////////////////////////////
  // submodules

  tst_wmem u_wmem (
    .clk_i(CLK_SYS_I),
    .a_addr_i(a_addr),
    .a_we_i(a_we),
    .a_wdata_i(a_wdata),
    .a_rdata_o(a_rdata),
    .b_addr_i(mem_addr_q),
    .b_we_i(WR_I && (ADDR_I == REG_MEM_DATA)),
    .b_wdata_i(WDATA_I),
    .b_rdata_o(b_rdata)
  );

  tst_ptr u_ptr (
    .ptr_i(ptr_cur),
    .len_i(len_q),
    .ok_o(ptr_ok),
    .wrap_o(ptr_wrap),
    .data_off_o(data_off),
    .ptr_next_o(ptr_next)
  );

  ////////////////////////////////////////////////////////////////////////
  // command decode

  assign wr_ctrl = WR_I && (ADDR_I == REG_CTRL);
  // busy lags idle by one cycle; refusing on it too keeps the start rule visible at the pins
  assign go_search = wr_ctrl && WDATA_I[CTRL_GO_SEARCH] && (state_q == ST_IDLE) && !BUSY_O;
  assign go_ttd = wr_ctrl && WDATA_I[CTRL_GO_TTD];
  // a pending transfer starts only from idle and never beside a new search
  assign ttd_start = ttd_pend_q && (state_q == ST_IDLE) && !go_search;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ttd_pend_q <= 1'b0;
    end else if (go_ttd || (SCAN_END_I && ttd_en_q)) begin
      ttd_pend_q <= 1'b1;
    end else if (ttd_start) begin
      ttd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ttd_en_q <= 1'b0;
      opnd_addr_q <= 1'b0;
    end else if (wr_ctrl) begin
      ttd_en_q <= WDATA_I[CTRL_TTD_EN];
      opnd_addr_q <= WDATA_I[CTRL_OPND_ADDR];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stack1_q <= RST_WORD;
      operand_q <= RST_WORD;
      dest_q <= '0;
      mem_addr_q <= '0;
      irq_mask_q <= RST_IRQ_MASK;
    end else if (WR_I) begin
      case (ADDR_I)
        REG_STACK1: begin
          stack1_q <= WDATA_I;
        end
        REG_OPERAND: begin
          operand_q <= WDATA_I;
        end
        REG_DEST: begin
          dest_q <= WDATA_I[ADDR_W-1:0];
        end
        REG_MEM_ADDR: begin
          mem_addr_q <= WDATA_I[ADDR_W-1:0];
        end
        REG_IRQ_MASK: begin
          irq_mask_q <= WDATA_I[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  assign hit = a_rdata > key_q;
  assign last = ({8'h00, len_q} == acc_q + 16'h0001);
  assign srch_empty = ((state_q == ST_SRCH) || (state_q == ST_OPWT)) && (len_q == 8'h00);
  // the pointer word is on the read port during the check state
  assign ptr_cur = (state_q == ST_PCHK) ? a_rdata : ptr_q;

  always_comb begin
    a_addr = base_q;
    a_we = 1'b0;
    a_wdata = data_q;
    case (state_q)
      ST_OPRD: begin
        a_addr = operand_q[ADDR_W-1:0];
      end
      ST_SRCH: begin
        a_addr = base_q + acc_q[ADDR_W-1:0];
      end
      ST_DRD: begin
        a_addr = base_q + data_off[ADDR_W-1:0];
      end
      ST_DWR: begin
        a_addr = dest_q;
        a_we = 1'b1;
        a_wdata = a_rdata;
      end
      ST_PWR: begin
        a_addr = base_q;
        a_we = 1'b1;
        a_wdata = ptr_next;
      end
      default: begin
        a_addr = base_q;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go_search) begin
            state_q <= WDATA_I[CTRL_OPND_ADDR] ? ST_OPRD : ST_SRCH;
          end else if (ttd_start) begin
            state_q <= ST_PRD;
          end
        end
        ST_OPRD: begin
          state_q <= ST_OPWT;
        end
        ST_OPWT: begin
          state_q <= (len_q == 8'h00) ? ST_IDLE : ST_SRCH;
        end
        ST_SRCH: begin
          state_q <= (len_q == 8'h00) ? ST_IDLE : ST_SCMP;
        end
        ST_SCMP: begin
          state_q <= (hit || last) ? ST_IDLE : ST_SRCH;
        end
        ST_PRD: begin
          state_q <= ST_PCHK;
        end
        ST_PCHK: begin
          state_q <= ptr_ok ? ST_DRD : ST_IDLE;
        end
        ST_DRD: begin
          state_q <= ST_DWR;
        end
        ST_DWR: begin
          state_q <= ST_PWR;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // operand latch and table parameters
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      base_q <= '0;
      len_q <= '0;
      key_q <= RST_WORD;
    end else if (go_search || ttd_start) begin
      base_q <= acc_q[ADDR_W-1:0];
      len_q <= stack1_q[LEN_W-1:0];
      key_q <= operand_q;
    end else if (state_q == ST_OPWT) begin
      key_q <= a_rdata;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ptr_q <= RST_WORD;
    end else if (state_q == ST_PCHK) begin
      ptr_q <= a_rdata;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      data_q <= RST_WORD;
    end else if (state_q == ST_DWR) begin
      data_q <= a_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator and flags

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      acc_q <= RST_WORD;
    end else if (go_search) begin
      acc_q <= RST_WORD;
    end else if ((state_q == ST_SRCH) && (len_q == 8'h00)) begin
      acc_q <= RST_WORD;
    end else if ((state_q == ST_SCMP) && !hit) begin
      acc_q <= last ? RST_WORD : acc_q + 16'h0001;
    end else if (WR_I && (ADDR_I == REG_ACC) && (state_q == ST_IDLE)) begin
      acc_q <= WDATA_I;
    end
  end

  // each search rewrites the fail flag
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SEARCH_FAIL_O <= 1'b0;
    end else if (go_search) begin
      SEARCH_FAIL_O <= 1'b0;
    end else if (srch_empty) begin
      SEARCH_FAIL_O <= 1'b1;
    end else if ((state_q == ST_SCMP) && !hit && last) begin
      SEARCH_FAIL_O <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      POINTER_WRAP_O <= 1'b0;
    end else if (state_q == ST_PCHK) begin
      POINTER_WRAP_O <= ptr_wrap;
    end else if (SCAN_END_I) begin
      POINTER_WRAP_O <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= (state_q != ST_IDLE) || go_search || ttd_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  always_comb begin
    irq_ev = '0;
    irq_ev[EV_SEARCH_DONE] = ((state_q == ST_SCMP) && (hit || last)) || srch_empty;
    irq_ev[EV_SEARCH_FAIL] = ((state_q == ST_SCMP) && !hit && last) || srch_empty;
    irq_ev[EV_TTD_DONE] = (state_q == ST_PWR);
    irq_ev[EV_WRAP] = (state_q == ST_PCHK) && ptr_wrap;
  end

  // set wins over the read-clear of the same cycle
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_stat_q <= '0;
    end else if (RD_I && (ADDR_I == REG_IRQ_STAT)) begin
      irq_stat_q <= irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  always_comb begin
    rdata_d = '0;
    case (ADDR_I)
      REG_CTRL: begin
        rdata_d[CTRL_TTD_EN] = ttd_en_q;
        rdata_d[CTRL_OPND_ADDR] = opnd_addr_q;
        rdata_d[CTRL_BUSY] = state_q != ST_IDLE;
      end
      REG_ACC: rdata_d = acc_q;
      REG_STACK1: rdata_d = stack1_q;
      REG_OPERAND: rdata_d = operand_q;
      REG_DEST: rdata_d[ADDR_W-1:0] = dest_q;
      REG_STATUS: begin
        rdata_d[STAT_FAIL] = SEARCH_FAIL_O;
        rdata_d[STAT_WRAP] = POINTER_WRAP_O;
      end
      REG_IRQ_STAT: rdata_d[IRQ_W-1:0] = irq_stat_q;
      REG_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
      REG_MEM_ADDR: rdata_d[ADDR_W-1:0] = mem_addr_q;
      REG_MEM_DATA: rdata_d = b_rdata;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= RST_WORD;
    end else if (RD_I) begin
      RDATA_O <= rdata_d;
    end else begin
      RDATA_O <= RST_WORD;
    end
  end

endmodule

`default_nettype wire

// ---- inc/tst_pkg.sv ----
// package of constants and types for the table search and transfer engine
package tst_pkg;

  // word memory geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MEM_DEPTH = 4096;
  localparam int unsigned LEN_W = 8;

  // register bus geometry
  localparam int unsigned REG_AW = 4;

  // register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ACC = 4'h1;
  localparam logic [3:0] REG_STACK1 = 4'h2;
  localparam logic [3:0] REG_OPERAND = 4'h3;
  localparam logic [3:0] REG_DEST = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK = 4'h7;
  localparam logic [3:0] REG_MEM_ADDR = 4'h8;
  localparam logic [3:0] REG_MEM_DATA = 4'h9;

  // control register fields
  localparam int unsigned CTRL_GO_SEARCH = 0;
  localparam int unsigned CTRL_GO_TTD = 1;
  localparam int unsigned CTRL_TTD_EN = 2;
  localparam int unsigned CTRL_OPND_ADDR = 3;
  localparam int unsigned CTRL_BUSY = 4;

  // status register fields
  localparam int unsigned STAT_FAIL = 0;
  localparam int unsigned STAT_WRAP = 1;

  // interrupt event bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_SEARCH_DONE = 0;
  localparam int unsigned EV_SEARCH_FAIL = 1;
  localparam int unsigned EV_TTD_DONE = 2;
  localparam int unsigned EV_WRAP = 3;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

  // pointer constants
  localparam logic [DATA_W-1:0] PTR_WRAP_VAL = 16'h0001;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_OPRD = 4'b0001,
    ST_OPWT = 4'b0010,
    ST_SRCH = 4'b0011,
    ST_SCMP = 4'b0100,
    ST_PRD = 4'b0101,
    ST_PCHK = 4'b0110,
    ST_DRD = 4'b0111,
    ST_DWR = 4'b1000,
    ST_PWR = 4'b1001
  } tst_state_e;

endpackage

// ---- design/tst_wmem.sv ----
// word memory with an engine port and a software port, both read-first
`timescale 1ns/1ps
`default_nettype none

module tst_wmem
  import tst_pkg::*;
(
  input wire logic clk_i,
  // engine port
  input wire logic [ADDR_W-1:0] a_addr_i,
  input wire logic a_we_i,
  input wire logic [DATA_W-1:0] a_wdata_i,
  output logic [DATA_W-1:0] a_rdata_o,
  // software port
  input wire logic [ADDR_W-1:0] b_addr_i,
  input wire logic b_we_i,
  input wire logic [DATA_W-1:0] b_wdata_i,
  output logic [DATA_W-1:0] b_rdata_o
);

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // on a same-address collision the engine write lands last and wins
  always_ff @(posedge clk_i) begin
    if (b_we_i) begin
      mem[b_addr_i] <= b_wdata_i;
    end
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end

endmodule

`default_nettype wire

// ---- design/tst_ptr.sv ----
// pointer step for the table-to-destination transfer
`timescale 1ns/1ps
`default_nettype none

module tst_ptr
  import tst_pkg::*;
(
  input wire logic [DATA_W-1:0] ptr_i,
  input wire logic [LEN_W-1:0] len_i,
  output logic ok_o,
  output logic wrap_o,
  output logic [DATA_W-1:0] data_off_o,
  output logic [DATA_W-1:0] ptr_next_o
);

  logic [DATA_W-1:0] len_w;

  assign len_w = {8'h00, len_i};

  // a pointer beyond the table length, or an empty table, moves nothing
  assign ok_o = (len_i != 8'h00) && (ptr_i <= len_w);

  assign wrap_o = ok_o && (ptr_i == len_w);

  assign data_off_o = ((ptr_i == 16'h0000) || wrap_o) ? PTR_WRAP_VAL : ptr_i + 16'h0001;

  assign ptr_next_o = wrap_o ? PTR_WRAP_VAL : ptr_i + 16'h0001;

endmodule

`default_nettype wire

// ---- bench/tst_engine_checker.sv ----
// assertion checker for the table search and transfer engine
`timescale 1ns/1ps
`default_nettype none

module tst_engine_checker
  import tst_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // register port
  input wire logic [REG_AW-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  // scan pacing and status
  input wire logic SCAN_END_I,
  input wire logic BUSY_O,
  input wire logic SEARCH_FAIL_O,
  input wire logic POINTER_WRAP_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);

  logic go_s;
  logic ctrl_wr;
  assign ctrl_wr = WR_I && (ADDR_I == REG_CTRL);
  assign go_s = ctrl_wr && WDATA_I[CTRL_GO_SEARCH] && !BUSY_O;

  ////////////////////////////////////////////////////////////////////////////
  a_read_data_idle: assert property (!RD_I |=> RDATA_O == 16'h0000)
    else $error("read data not zero outside a read slot");
  a_search_start: assert property (go_s |=> BUSY_O && !SEARCH_FAIL_O)
    else $error("search start did not clear fail and raise busy");
  a_fail_from_search: assert property ($rose(SEARCH_FAIL_O) |-> $past(BUSY_O))
    else $error("fail flag rose without a running search");
  a_fail_kept: assert property (SEARCH_FAIL_O && !go_s |=> SEARCH_FAIL_O)
    else $error("fail flag dropped without a new search");
  a_wrap_from_xfer: assert property ($rose(POINTER_WRAP_O) |-> $past(BUSY_O))
    else $error("wrap flag rose without a running transfer");
  a_wrap_scan_clear: assert property (SCAN_END_I && !BUSY_O |=> !POINTER_WRAP_O)
    else $error("wrap flag outlived the scan end");
  a_busy_bounded: assert property ($rose(BUSY_O) |-> ##[1:600] !BUSY_O)
    else $error("operation ran past the longest table");
  a_busy_cause: assert property ($rose(BUSY_O) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(SCAN_END_I, 2) || $past(BUSY_O, 2))
    else $error("engine started with no start request");
endmodule

bind tst_engine tst_engine_checker u_chk (.*);
`default_nettype wire

// ---- bench/tst_scan_model.sv ----
// sequencer model: paces program scans with end-of-scan pulses
`timescale 1ns/1ps
`default_nettype none

module tst_scan_model #(
  parameter int PERIOD = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control and pacing
  input wire logic run_i,
  output logic scan_end_o
);
  logic [7:0] cnt_q;

  // period kept above a transfer so a held enable gives one run a scan
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      scan_end_o <= 1'b0;
    end else begin
      scan_end_o <= run_i && (cnt_q == 8'(PERIOD - 1));
      cnt_q <= (!run_i || cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tst_engine_tb.sv ----
// self-checking testbench for the table search and transfer engine
`timescale 1ns/1ps
`default_nettype none

module tst_engine_tb;
  import tst_pkg::*;
  logic clk, rst_n, wr, rd, run, busy, fail, wrap, irq, scan_end;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, v, mask;
  logic [15:0] m [0:255];
  logic [31:0] sd = 32'hada8fed7;
  logic [7:0] p, d;
  int n_fail = 0;
  int compares = 0;
  int nsc = 0;
  int i;

  tst_engine u_tst_engine (.CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SCAN_END_I(scan_end), .BUSY_O(busy),
    .SEARCH_FAIL_O(fail), .POINTER_WRAP_O(wrap), .IRQ_O(irq));
  tst_scan_model #(.PERIOD(16)) u_tst_scan_model (.clk_i(clk), .rst_n_i(rst_n), .run_i(run),
    .scan_end_o(scan_end));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (scan_end === 1'b1) nsc <= nsc + 1;

  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // unsigned, ascending, first hit wins; miss gives fail with zero offset
  function logic [16:0] sx(input logic [7:0] b, input logic [7:0] l, input logic [15:0] op);
    for (int j = 0; j < l; j++) if (m[8'(b + j)] > op) return {1'b0, 16'(j)};
    return {1'b1, 16'h0000};
  endfunction

  task chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wrr(input logic [3:0] a, input logic [15:0] dt);
    @(posedge clk);
    addr <= a;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdr(input logic [3:0] a, output logic [15:0] dt);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 dt = rdata;
  endtask
  task mw(input logic [7:0] a, input logic [15:0] dt);
    wrr(REG_MEM_ADDR, {8'h00, a});
    wrr(REG_MEM_DATA, dt);
    m[a] = dt;
  endtask
  task mr(input logic [7:0] a, output logic [15:0] dt);
    wrr(REG_MEM_ADDR, {8'h00, a});
    rdr(REG_MEM_DATA, dt);
  endtask
  // a pending transfer starts one cycle late, so give busy two edges to show
  task wt;
    repeat (2) @(posedge clk);
    for (int j = 0; j < 800 && busy !== 1'b0; j++) @(posedge clk);
    chk(busy, 1'b0);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task srch(input logic [7:0] b, input logic [7:0] l, input logic [15:0] op, input logic ind);
    logic [16:0] e;
    if (ind) mw(8'hff, op);
    e = sx(b, l, op);
    wrr(REG_ACC, {8'h00, b});
    wrr(REG_STACK1, {8'h00, l});
    wrr(REG_OPERAND, ind ? 16'h00ff : op);
    wrr(REG_CTRL, ind ? 16'h0009 : 16'h0001);
    wt;
    rdr(REG_ACC, v);
    chk(v, e[15:0]);
    chk(fail, e[16]);
    chk(irq, |mask);
    rdr(REG_IRQ_STAT, v);
    chk(v, {14'h0, e[16], 1'b1});
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
  endtask
  // table of three data words behind the pointer word at 80
  task xfer;
    logic w;
    w = (p == 8'h03);
    d = 8'h81 + ((p == 8'h00 || w) ? 8'h00 : p);
    p = w ? 8'h01 : p + 8'h01;
  endtask
  task scans(input int n);
    int k0;
    k0 = nsc;
    @(posedge clk);
    run <= 1'b1;
    for (int j = 0; j < 40 * n && nsc < k0 + n; j++) @(posedge clk);
    run <= 1'b0;
    wt;
  endtask

  task finish_test;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  initial begin
    rst_n = 1'b0;
    {wr, rd, run, addr, wdata, mask, p} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdr(REG_ACC, v);
    chk(v, RST_WORD);
    rdr(REG_IRQ_MASK, v);
    chk(v, 16'h0000);
    wrr(4'hf, 16'hffff);
    rdr(4'hf, v);
    chk(v, 16'h0000);
    for (i = 0; i < 256; i++) begin
      sd = nx(sd);
      mw(i[7:0], sd[15:0]);
    end
    srch(8'h10, 8'h00, 16'h0000, 1'b0);
    srch(8'h00, 8'hff, 16'hffff, 1'b1);
    mask = 16'h000f;
    wrr(REG_IRQ_MASK, mask);
    srch(8'h20, 8'h08, m[8'h24], 1'b0);
    for (i = 0; i < 8; i++) begin
      sd = nx(sd);
      srch({2'b00, sd[5:0]}, {1'b0, sd[13:7]}, sd[31:16] | 16'hf000, sd[6]);
    end
    wrr(REG_ACC, 16'h0080);
    wrr(REG_STACK1, 16'h0003);
    wrr(REG_DEST, 16'h00f0);
    mw(8'h80, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wrr(REG_CTRL, 16'h0002);
      wt;
      chk(wrap, i == 3);
      xfer;
      mr(8'hf0, v);
      chk(v, m[d]);
      mr(8'h80, v);
      chk(v, {8'h00, p});
      rdr(REG_IRQ_STAT, v);
      chk(v, {12'h0, i == 3, 3'b100});
    end
    scans(1);
    chk(wrap, 1'b0);
    wrr(REG_CTRL, 16'h0004);
    rdr(REG_CTRL, v);
    chk(v, 16'h0004);
    scans(3);
    wrr(REG_CTRL, 16'h0000);
    wt;
    repeat (3) xfer;
    mr(8'h80, v);
    chk(v, {8'h00, p});
    mr(8'hf0, v);
    chk(v, m[d]);
    finish_test;
  end
endmodule
`default_nettype wire
